// ===== tct_core_tick_timer.sv
// core_tick_timer: ahb-lite register slave around the tick down counter
`timescale 1ns/100ps
`default_nettype none
module tct_core_tick_timer (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output var  logic        hreadyout,
	output var  logic        hresp,
	output var  logic [31:0] hrdata
);
	import tct_pkg::*;

	// register decode selects, one per mapped word plus one for no match
	typedef enum {
		TCT_SEL_NONE,
		TCT_SEL_CTRL,
		TCT_SEL_RELOAD,
		TCT_SEL_CURRENT
	} tct_sel_e;

	// address phase bookkeeping
	logic        accept;
	logic        in_window;
	tct_sel_e    addr_sel;
	logic        rd_ctrl;

	// data phase state
	logic        wr_pend;
	logic        next_wr_pend;
	tct_sel_e    wr_sel;
	tct_sel_e    next_wr_sel;

	// software visible state
	tct_cfg_s    cfg;
	tct_cfg_s    next_cfg;
	logic        flag;
	logic        next_flag;
	logic [31:0] next_hrdata;
	logic        next_hreadyout;
	logic        next_hresp;

	// counter hookup
	logic        clear_count;
	tct_stat_s   stat;

	// hsize is not checked: only whole words are ever issued
	assign accept = hsel && htrans[1] && hready;

	// window check before the exact word match
	assign in_window = (haddr >= TCT_WIN_LO) && (haddr <= TCT_WIN_HI);

	// word decode inside the window; other words read zero
	always_comb begin
		addr_sel = TCT_SEL_NONE;
		if (in_window) begin
			unique case (haddr)
				TCT_CTRL_ADDR:    addr_sel = TCT_SEL_CTRL;
				TCT_RELOAD_ADDR:  addr_sel = TCT_SEL_RELOAD;
				TCT_CURRENT_ADDR: addr_sel = TCT_SEL_CURRENT;
				default:          addr_sel = TCT_SEL_NONE;
			endcase
		end
	end

	// a read of the status word is acted on at its address phase
	assign rd_ctrl = accept && !hwrite && (addr_sel == TCT_SEL_CTRL);

	// remember a write so its data can be taken one cycle later
	always_comb begin
		next_wr_pend = 1'b0;
		next_wr_sel  = TCT_SEL_NONE;
		if (accept && hwrite) begin
			next_wr_pend = 1'b1;
			next_wr_sel  = addr_sel;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			wr_sel  <= TCT_SEL_NONE;
		end else begin
			wr_pend <= next_wr_pend;
			wr_sel  <= next_wr_sel;
		end
	end

	// write data lands at the end of the data phase
	always_comb begin
		next_cfg = cfg;
		if (wr_pend && wr_sel == TCT_SEL_CTRL) begin
			next_cfg.enable = hwdata[TCT_EN_BIT];
		end
		if (wr_pend && wr_sel == TCT_SEL_RELOAD) begin
			// only stored; the counter picks it up at zero
			next_cfg.reload = hwdata[TCT_CNT_W-1:0];
		end
	end

	// the clear reaches the counter in the data phase of the write
	assign clear_count = wr_pend && (wr_sel == TCT_SEL_CURRENT);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cfg.enable <= TCT_EN_RST;
			cfg.reload <= TCT_RELOAD_RST;
		end else begin
			cfg <= next_cfg;
		end
	end

	// sticky wrap flag; a new wrap outranks the read that clears it
	always_comb begin
		next_flag = flag;
		if (rd_ctrl) begin
			next_flag = 1'b0;
		end
		if (stat.wrap) begin
			next_flag = 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flag <= TCT_FLAG_RST;
		end else begin
			flag <= next_flag;
		end
	end

	// read data is registered at the address phase edge, so a read
	// right behind a write to the same word returns the old value
	always_comb begin
		next_hrdata = TCT_WORD_ZERO;
		if (accept && !hwrite) begin
			unique case (addr_sel)
				TCT_SEL_CTRL: begin
					next_hrdata[TCT_EN_BIT]   = cfg.enable;
					next_hrdata[TCT_FLAG_BIT] = flag;
				end
				TCT_SEL_RELOAD: begin
					next_hrdata[TCT_CNT_W-1:0] = cfg.reload;
				end
				TCT_SEL_CURRENT: begin
					next_hrdata[TCT_CNT_W-1:0] = stat.count;
				end
				TCT_SEL_NONE: begin
					next_hrdata = TCT_WORD_ZERO;
				end
			endcase
		end
	end

	// never stretches a transfer and never signals an error
	always_comb begin
		next_hreadyout = 1'b1;
		next_hresp     = TCT_HRESP_OKAY;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata    <= TCT_WORD_ZERO;
			hreadyout <= 1'b1;
			hresp     <= TCT_HRESP_OKAY;
		end else begin
			hrdata    <= next_hrdata;
			hreadyout <= next_hreadyout;
			hresp     <= next_hresp;
		end
	end

	// counting engine; runs every clock, gated by the enable bit, with a current value write clearing it first
	tct_counter u_counter (
		.clk   (hclk),
		.rst_n (hresetn),
		.cfg   (cfg),
		.clear (clear_count),
		.stat  (stat)
	);

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_flag_read_clear: assert property (
		(rd_ctrl && !stat.wrap) |=> !flag)
		else $error("status read did not clear wrap flag");

	a_flag_set_wins: assert property (
		(rd_ctrl && stat.wrap) |=> flag)
		else $error("wrap lost against a status read");

	a_flag_sticky: assert property (
		(flag && !rd_ctrl) |=> flag)
		else $error("wrap flag dropped without a read");

	a_flag_on_wrap: assert property (
		(stat.wrap && !rd_ctrl) ##1 !rd_ctrl |=> flag)
		else $error("wrap flag not set after wrap");

	a_flag_readback: assert property (
		rd_ctrl |=> (hrdata[TCT_FLAG_BIT] == $past(flag)
			&& hrdata[TCT_EN_BIT] == $past(cfg.enable)))
		else $error("status word readback wrong");

	a_reload_defer: assert property (
		(wr_pend && wr_sel == TCT_SEL_RELOAD && cfg.enable
			&& stat.count > TCT_CNT_ONE)
		|=> (stat.count == $past(stat.count) - TCT_CNT_ONE))
		else $error("reload write disturbed the running count");

	a_current_clear: assert property (
		(accept && hwrite && addr_sel == TCT_SEL_CURRENT)
		|=> ##1 (stat.count == TCT_CNT_ZERO))
		else $error("write to current value did not clear it");

	a_window_read: assert property (
		(accept && !hwrite && !in_window) |=> (hrdata == TCT_WORD_ZERO))
		else $error("read outside window returned data");

	a_count_read: assert property (
		(accept && !hwrite && addr_sel == TCT_SEL_CURRENT)
		|=> (hrdata[TCT_CNT_W-1:0] == $past(stat.count)
			&& hrdata[31:TCT_CNT_W] == 8'h00))
		else $error("current value readback wrong");

	a_bus_okay: assert property (
		accept |=> (hreadyout && hresp == TCT_HRESP_OKAY)[*2])
		else $error("slave stretched or refused a transfer");

	// register writes land as written and nowhere else
	a_enable_write: assert property (
		(wr_pend && wr_sel == TCT_SEL_CTRL)
		|=> (cfg.enable == $past(hwdata[TCT_EN_BIT])))
		else $error("enable bit write did not land");

	a_reload_write: assert property (
		(wr_pend && wr_sel == TCT_SEL_RELOAD)
		|=> (cfg.reload == $past(hwdata[TCT_CNT_W-1:0])))
		else $error("reload write did not land");

	a_reload_hold: assert property (
		!(wr_pend && wr_sel == TCT_SEL_RELOAD) |=> $stable(cfg.reload))
		else $error("reload value changed without a write");

	a_enable_hold: assert property (
		!(wr_pend && wr_sel == TCT_SEL_CTRL) |=> $stable(cfg.enable))
		else $error("enable bit changed without a write");

	a_stray_write: assert property (
		(wr_pend && wr_sel == TCT_SEL_NONE) |=> $stable(cfg))
		else $error("unmapped write changed the setup");

	// flag moves only on a wrap or a status read
	a_flag_rise: assert property (
		$rose(flag) |-> $past(stat.wrap))
		else $error("wrap flag set without a wrap");

	a_flag_fall: assert property (
		$fell(flag) |-> $past(rd_ctrl))
		else $error("wrap flag cleared without a status read");

	a_wrap_kept: assert property (
		stat.wrap |=> flag)
		else $error("wrap did not reach the flag");

	a_clear_no_flag: assert property (
		(clear_count && !flag && !stat.wrap) |=> !flag)
		else $error("current value write set the wrap flag");

	a_disabled_hold: assert property (
		(!cfg.enable && !clear_count) |=> $stable(stat.count))
		else $error("count moved while disabled");

	// read data stands for its data phase only
	a_rdata_idle: assert property (
		!(accept && !hwrite) |=> (hrdata == TCT_WORD_ZERO))
		else $error("read data left standing outside a read");

	a_reload_read: assert property (
		(accept && !hwrite && addr_sel == TCT_SEL_RELOAD)
		|=> (hrdata == {8'h00, $past(cfg.reload)}))
		else $error("reload value readback wrong");
endmodule // tct_core_tick_timer
`default_nettype wire

// ===== tct_core_tick_timer_tb_top.sv
// self-checking bench for the core tick timer register slave
`timescale 1ns/100ps
`default_nettype none
module tct_core_tick_timer_tb_top;
	import tct_pkg::*;
	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	wire logic   hready;
	logic        hresp;
	logic [31:0] hrdata;
	logic [31:0] rd;
	logic [31:0] v1;
	int          bad_count;
	int          comparisons;
	int          seed;
	int          rl;
	int          gap;
	int          hits;

	// single slave, so its ready is the bus ready
	tct_core_tick_timer i_dut (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hsize     (hsize),
		.hwdata    (hwdata),
		.hready    (hready),
		.hreadyout (hready),
		.hresp     (hresp),
		.hrdata    (hrdata)
	);

	// 25 MHz bus clock
	initial begin
		hclk = 1'b0;
		forever #20 hclk = ~hclk;
	end

	task automatic complete_run;
		$display("mismatches %0d, comparisons %0d", bad_count, comparisons);
		if (bad_count == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// one single transfer; caller stands just after a rising edge
	task automatic bus(input logic wr, input logic [31:0] addr,
		input logic [31:0] wd);
		hsel   <= 1'b1;
		haddr  <= addr;
		htrans <= 2'h2;
		hwrite <= wr;
		hsize  <= 3'h2;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		htrans <= TCT_HTRANS_IDLE;
		hwdata <= wd;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		rd = hrdata;
		check({31'h0, hresp}, {31'h0, TCT_HRESP_OKAY});
		check({31'h0, hready}, 32'h0000_0001);
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge hclk);
	endtask

	// count expected d clocks later in a period of r+1 states
	function automatic logic [31:0] back(input int v, input int d, input int r);
		return 32'((v + (r + 1) * 8 - d) % (r + 1));
	endfunction

	// hang guard, far beyond the thousand or so cycles needed
	initial begin
		idle(20000);
		bad_count++;
		$display("[FAIL] %0t: run did not finish", $time);
		complete_run;
	end

	initial begin
		seed = 51582;
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = TCT_WORD_ZERO;
		htrans = TCT_HTRANS_IDLE;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = TCT_WORD_ZERO;
		idle(8);
		hresetn <= 1'b1;
		idle(1);
		bus(0, TCT_CTRL_ADDR, 0);
		check(rd, TCT_WORD_ZERO);
		bus(0, TCT_RELOAD_ADDR, 0);
		check(rd, TCT_WORD_ZERO);
		// outside the window and unmapped inside it
		bus(1, 32'hE000_E114, 32'h0000_0055);
		bus(0, TCT_RELOAD_ADDR, 0);
		check(rd, TCT_WORD_ZERO);
		bus(0, 32'hE000_E01C, 0);
		check(rd, TCT_WORD_ZERO);
		// a deselected write must not reach the reload value
		hsel   <= 1'b0;
		haddr  <= TCT_RELOAD_ADDR;
		htrans <= 2'h2;
		hwrite <= 1'b1;
		idle(1);
		htrans <= TCT_HTRANS_IDLE;
		hwdata <= 32'h0000_0077;
		idle(1);
		bus(0, TCT_RELOAD_ADDR, 0);
		check(rd, TCT_WORD_ZERO);
		// long free run from the largest 24-bit reload
		bus(1, TCT_RELOAD_ADDR, 32'h00FF_FFFF);
		bus(1, TCT_CURRENT_ADDR, $random(seed));
		bus(1, TCT_CTRL_ADDR, 32'h0000_0001);
		idle(4);
		repeat (6) begin
			gap = $unsigned($random(seed)) % 16;
			bus(0, TCT_CURRENT_ADDR, 0);
			v1 = rd;
			idle(gap);
			bus(0, TCT_CURRENT_ADDR, 0);
			check(v1 - rd, 32'(gap + 2));
			check(32'(v1 >= 32'h00FF_0000), 32'h1);
			check(rd & 32'hFF00_0000, TCT_WORD_ZERO);
		end
		// disabled count holds, a write clears it
		bus(1, TCT_CTRL_ADDR, 0);
		bus(0, TCT_CURRENT_ADDR, 0);
		v1 = rd;
		idle(5);
		bus(0, TCT_CURRENT_ADDR, 0);
		check(rd, v1);
		bus(1, TCT_CURRENT_ADDR, 32'hA5A5_A5A5);
		idle(2);
		bus(0, TCT_CURRENT_ADDR, 0);
		check(rd, TCT_WORD_ZERO);
		// short random period, sampled at random spacing
		rl = 20 + $unsigned($random(seed)) % 40;
		bus(1, TCT_RELOAD_ADDR, 32'(rl));
		bus(1, TCT_CTRL_ADDR, 32'h0000_0001);
		bus(0, TCT_CTRL_ADDR, 0);
		check(rd, 32'h0000_0001);
		repeat (8) begin
			gap = $unsigned($random(seed)) % 16;
			bus(0, TCT_CURRENT_ADDR, 0);
			v1 = rd;
			idle(gap);
			bus(0, TCT_CURRENT_ADDR, 0);
			check(32'(v1 <= 32'(rl)), 32'h1);
			check(rd, back(int'(v1), gap + 2, rl));
		end
		// flag survives a write, then clears on its read
		idle(rl + 4);
		bus(1, TCT_CTRL_ADDR, 0);
		// a wrap racing the disable must land before the first read
		idle(2);
		bus(0, TCT_CTRL_ADDR, 0);
		check(rd, 32'h0001_0000);
		bus(0, TCT_CTRL_ADDR, 0);
		check(rd, TCT_WORD_ZERO);
		// period of three against reads every two clocks
		bus(1, TCT_RELOAD_ADDR, 32'h0000_0002);
		bus(1, TCT_CURRENT_ADDR, 0);
		bus(1, TCT_CTRL_ADDR, 32'h0000_0001);
		bus(0, TCT_CTRL_ADDR, 0);
		hits = 0;
		repeat (30) begin
			bus(0, TCT_CTRL_ADDR, 0);
			hits += int'(rd[16] === 1'b1);
		end
		check(32'(hits >= 19 && hits <= 21), 32'h1);
		// zero reload parks the counter with no new flag
		bus(1, TCT_RELOAD_ADDR, 0);
		idle(6);
		bus(0, TCT_CTRL_ADDR, 0);
		bus(0, TCT_CURRENT_ADDR, 0);
		check(rd, TCT_WORD_ZERO);
		bus(0, TCT_CTRL_ADDR, 0);
		check(rd, 32'h0000_0001);
		// new reload waits for the next wrap
		bus(1, TCT_RELOAD_ADDR, 32'h0000_0258);
		bus(1, TCT_CURRENT_ADDR, 0);
		idle(4);
		bus(1, TCT_RELOAD_ADDR, 32'h0000_0005);
		bus(0, TCT_CURRENT_ADDR, 0);
		check(32'(rd >= 32'h0000_023A && rd <= 32'h0000_0258), 32'h1);
		idle(610);
		bus(0, TCT_CURRENT_ADDR, 0);
		check(32'(rd <= 32'h0000_0005), 32'h1);
		// second reset in mid-run
		hresetn <= 1'b0;
		idle(2);
		hresetn <= 1'b1;
		idle(1);
		bus(0, TCT_CTRL_ADDR, 0);
		check(rd, TCT_WORD_ZERO);
		bus(0, TCT_RELOAD_ADDR, 0);
		check(rd, TCT_WORD_ZERO);
		complete_run;
	end
endmodule // tct_core_tick_timer_tb_top
`default_nettype wire

// ===== tct_counter.sv
// 24-bit down counter with reload and wrap pulse
`timescale 1ns/100ps
`default_nettype none
module tct_counter (
	input  wire logic           clk,
	input  wire logic           rst_n,
	input  wire tct_pkg::tct_cfg_s cfg,
	input  wire logic           clear,
	output var  tct_pkg::tct_stat_s stat
);
	import tct_pkg::*;

	logic [23:0] count;
	logic [23:0] next_count;
	logic        wrap;
	logic        next_wrap;

	// clear beats counting so a write always lands at zero
	always_comb begin
		next_count = count;
		next_wrap  = 1'b0;
		if (clear) begin
			next_count = TCT_CNT_ZERO;
		end else if (cfg.enable) begin
			if (count == TCT_CNT_ZERO) begin
				// reload of zero keeps it parked at zero
				next_count = cfg.reload;
			end else begin
				next_count = count - TCT_CNT_ONE;
				next_wrap  = (count == TCT_CNT_ONE);
			end
		end
	end

	// count value after reset carries no meaning
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count <= TCT_CUR_RST;
			wrap  <= 1'b0;
		end else begin
			count <= next_count;
			wrap  <= next_wrap;
		end
	end

	assign stat = '{count: count, wrap: wrap};

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_count_down: assert property (
		(cfg.enable && !clear && count != TCT_CNT_ZERO)
		|=> (count == $past(count) - TCT_CNT_ONE))
		else $error("counter did not step down by one");

	a_reload_zero: assert property (
		(cfg.enable && !clear && count == TCT_CNT_ZERO)
		|=> (count == $past(cfg.reload)))
		else $error("counter not reloaded after zero");

	a_wrap_set: assert property (
		(cfg.enable && !clear && count == TCT_CNT_ONE)
		|=> (wrap && count == TCT_CNT_ZERO))
		else $error("wrap pulse missing on reaching zero");

	a_wrap_only: assert property (
		wrap |-> ($past(count) == TCT_CNT_ONE && count == TCT_CNT_ZERO))
		else $error("wrap pulse without a transition to zero");

	a_zero_hold: assert property (
		(cfg.enable && !clear && count == TCT_CNT_ZERO
			&& cfg.reload == TCT_CNT_ZERO)
		|=> (count == TCT_CNT_ZERO && !wrap))
		else $error("zero reload did not park the counter");

	a_write_clear: assert property (
		clear |=> (count == TCT_CNT_ZERO && !wrap))
		else $error("write to current value did not clear it");
endmodule // tct_counter
`default_nettype wire

// ===== tct_pkg.sv
// constants and carrier types for the core tick timer
`default_nettype none
package tct_pkg;
	// counter geometry
	localparam int          TCT_CNT_W   = 24;
	localparam logic [23:0] TCT_CNT_ZERO = 24'h000000;
	localparam logic [23:0] TCT_CNT_ONE  = 24'h000001;

	// system control space window that holds the timer
	localparam logic [31:0] TCT_WIN_LO = 32'hE000_E010;
	localparam logic [31:0] TCT_WIN_HI = 32'hE000_E0FF;
	// full system control space addresses of the three registers, not offsets from a base
	localparam logic [31:0] TCT_CTRL_ADDR    = 32'hE000_E010;
	localparam logic [31:0] TCT_RELOAD_ADDR  = 32'hE000_E014;
	localparam logic [31:0] TCT_CURRENT_ADDR = 32'hE000_E018;

	// control and status word fields
	localparam int TCT_EN_BIT   = 0;
	localparam int TCT_FLAG_BIT = 16;

	// values after reset
	localparam logic        TCT_EN_RST     = 1'b0;
	localparam logic        TCT_FLAG_RST   = 1'b0;
	localparam logic [23:0] TCT_RELOAD_RST = 24'h000000;
	// software must treat this as undefined
	localparam logic [23:0] TCT_CUR_RST    = 24'h000000;
	localparam logic [31:0] TCT_WORD_ZERO  = 32'h0000_0000;

	// ahb transfer and response codes
	localparam logic [1:0] TCT_HTRANS_IDLE = 2'h0;
	localparam logic       TCT_HRESP_OKAY  = 1'b0;

	// what software sets up for the counter
	typedef struct packed {
		logic        enable;
		logic [23:0] reload;
	} tct_cfg_s;

	// what the counter reports back
	typedef struct packed {
		logic [23:0] count;
		logic        wrap;
	} tct_stat_s;
endpackage
`default_nettype wire
